/* File: design/mas_pkg.sv */
// Shared constants and types for the multiply-accumulate status block
package mas_pkg;
    localparam int ACC_W = 32;
    localparam int ACC_MSB = ACC_W - 1;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;
    localparam int CSR_W = 8;
    localparam int INT_W = 2;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CSR = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ACC = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_INT_CLR = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_INT_EN = 4'h4;

    // Control and status field positions
    localparam int BIT_FRAC = 7;
    localparam int BIT_SAT = 6;
    localparam int BIT_STICKY_OVERFLOW_FLAG = 2;
    localparam int BIT_OVF = 1;
    localparam int BIT_STICKY_SATURATION_FLAG = 0;

    // Interrupt status bit positions
    localparam int INT_SAT = 0;
    localparam int INT_OVF = 1;

    // Limits and reset values
    localparam logic [ACC_W-1:0] ACC_MAX = 32'h7fffffff;
    localparam logic [ACC_W-1:0] ACC_MIN = 32'h80000000;
    localparam logic [ACC_W-1:0] ACC_RST = 32'h00000000;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;

    typedef struct packed {
        logic valid;
        logic signedOp;
        logic [ACC_W-1:0] addend;
    } mas_acc_req_t;

    typedef struct packed {
        logic fracEn;
        logic satEn;
        logic stickyOvf;
        logic ovf;
        logic stickySat;
    } mas_csr_t;

    localparam mas_csr_t CSR_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage : mas_pkg

/* File: design/mas_accumulator.sv */
// Accumulator with fractional and saturation modes, flags and register port
`timescale 1ns/1ps

module mas_accumulator (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [mas_pkg::ADDR_W-1:0] regAddr,
    input wire logic [mas_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [mas_pkg::DATA_W-1:0] regRdData,
    input wire mas_pkg::mas_acc_req_t accReq,
    output logic [mas_pkg::ACC_W-1:0] accValue,
    output logic accDone,
    output logic irq
);
    import mas_pkg::*;

    mas_csr_t csr_q;
    mas_csr_t csr_d;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [INT_W-1:0] intStat_q;
    logic [INT_W-1:0] intStat_d;
    logic [INT_W-1:0] intEn_q;
    logic [INT_W-1:0] intEn_d;
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;
    logic irq_q;
    logic irq_d;
    logic done_q;
    logic done_d;

    logic [ACC_W-1:0] addEff;
    logic [ACC_W:0] sum;
    logic carry;
    logic sgnOvf;
    logic ovfEvt;
    logic satEvt;
    logic [CSR_W-1:0] csrRead;
    logic wrCsr;
    logic wrAcc;
    logic wrClr;
    logic wrEn;

    // Write decode
    always_comb
    begin
        wrCsr = 1'b0;
        wrAcc = 1'b0;
        wrClr = 1'b0;
        wrEn = 1'b0;
        if (regWrite && regAddr == OFS_CSR)
        begin
            wrCsr = 1'b1;
        end
        else if (regWrite && regAddr == OFS_ACC)
        begin
            wrAcc = 1'b1;
        end
        else if (regWrite && regAddr == OFS_INT_CLR)
        begin
            wrClr = 1'b1;
        end
        else if (regWrite && regAddr == OFS_INT_EN)
        begin
            wrEn = 1'b1;
        end
    end

    // Datapath: effective addend, sum and overflow detection
    always_comb
    begin
        addEff = accReq.addend;
        if (accReq.signedOp && csr_q.fracEn)
        begin
            addEff = {accReq.addend[ACC_MSB-1:0], 1'b0};
        end
        sum = {1'b0, acc_q} + {1'b0, addEff};
        carry = sum[ACC_W];
        // Same input signs, result sign opposite
        sgnOvf = (acc_q[ACC_MSB] == addEff[ACC_MSB])
            && (sum[ACC_MSB] != acc_q[ACC_MSB]);
    end

    // Accumulator, flags and events
    always_comb
    begin
        csr_d = csr_q;
        acc_d = acc_q;
        ovfEvt = 1'b0;
        satEvt = 1'b0;
        done_d = accReq.valid;
        if (wrCsr)
        begin
            csr_d.fracEn = regWrData[BIT_FRAC];
            csr_d.satEn = regWrData[BIT_SAT];
            // Writing zero clears a sticky flag, one leaves it
            csr_d.stickyOvf = csr_q.stickyOvf & regWrData[BIT_STICKY_OVERFLOW_FLAG];
            csr_d.stickySat = csr_q.stickySat & regWrData[BIT_STICKY_SATURATION_FLAG];
        end
        if (wrAcc)
        begin
            acc_d = regWrData[ACC_W-1:0];
        end
        if (accReq.valid)
        begin
            if (!accReq.signedOp)
            begin
                // Mode bits have no effect here
                acc_d = sum[ACC_W-1:0];
                csr_d.ovf = carry;
                ovfEvt = carry;
            end
            else if (csr_q.satEn && sgnOvf)
            begin
                // Clamp toward the side the sum ran off
                acc_d = acc_q[ACC_MSB] ? ACC_MIN : ACC_MAX;
                csr_d.ovf = 1'b0;
                satEvt = 1'b1;
            end
            else
            begin
                // Plain add also resumes from a saturated value
                acc_d = sum[ACC_W-1:0];
                csr_d.ovf = sgnOvf;
                ovfEvt = sgnOvf && !csr_q.satEn;
            end
        end
        // Hardware set wins over a software clear
        if (ovfEvt)
        begin
            csr_d.stickyOvf = 1'b1;
        end
        if (satEvt)
        begin
            csr_d.stickySat = 1'b1;
        end
    end

    // Interrupt status, enable and output level
    always_comb
    begin
        intEn_d = intEn_q;
        intStat_d = intStat_q;
        if (wrEn)
        begin
            intEn_d = regWrData[INT_W-1:0];
        end
        if (wrClr)
        begin
            intStat_d = intStat_q & ~regWrData[INT_W-1:0];
        end
        intStat_d[INT_OVF] = intStat_d[INT_OVF] | ovfEvt;
        intStat_d[INT_SAT] = intStat_d[INT_SAT] | satEvt;
        irq_d = |(intStat_d & intEn_d);
    end

    // Read path, data stand one cycle after the strobe
    always_comb
    begin
        csrRead = '0;
        csrRead[BIT_FRAC] = csr_q.fracEn;
        csrRead[BIT_SAT] = csr_q.satEn;
        csrRead[BIT_STICKY_OVERFLOW_FLAG] = csr_q.stickyOvf;
        csrRead[BIT_OVF] = csr_q.ovf;
        csrRead[BIT_STICKY_SATURATION_FLAG] = csr_q.stickySat;
        rdData_d = RD_ZERO;
        if (regRead && regAddr == OFS_CSR)
        begin
            rdData_d = DATA_W'(csrRead);
        end
        else if (regRead && regAddr == OFS_ACC)
        begin
            rdData_d = DATA_W'(acc_q);
        end
        else if (regRead && regAddr == OFS_INT_STAT)
        begin
            rdData_d = DATA_W'(intStat_q);
        end
        else if (regRead && regAddr == OFS_INT_EN)
        begin
            rdData_d = DATA_W'(intEn_q);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            csr_q <= CSR_RST;
            acc_q <= ACC_RST;
            intStat_q <= INT_RST;
            intEn_q <= INT_RST;
            rdData_q <= RD_ZERO;
            irq_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            csr_q <= csr_d;
            acc_q <= acc_d;
            intStat_q <= intStat_d;
            intEn_q <= intEn_d;
            rdData_q <= rdData_d;
            irq_q <= irq_d;
            done_q <= done_d;
        end
    end

    assign regRdData = rdData_q;
    assign accValue = acc_q;
    assign accDone = done_q;
    assign irq = irq_q;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    logic sgnReq;
    assign sgnReq = accReq.valid && accReq.signedOp;

    AST_UNS_CARRY: assert property (
        accReq.valid && !accReq.signedOp && carry |=> csr_q.stickyOvf && csr_q.ovf)
        else $error("unsigned carry did not raise overflow flags");

    AST_SGN_OVF: assert property (
        sgnReq && !csr_q.satEn && sgnOvf |=> csr_q.stickyOvf && csr_q.ovf)
        else $error("signed overflow did not raise overflow flags");

    AST_STICKY_HOLD: assert property (
        csr_q.stickyOvf && !(wrCsr && !regWrData[BIT_STICKY_OVERFLOW_FLAG]) |=> csr_q.stickyOvf)
        else $error("sticky overflow cleared without a write");

    AST_STICKY_SATURATION_FLAG_HOLD: assert property (
        csr_q.stickySat && !(wrCsr && !regWrData[BIT_STICKY_SATURATION_FLAG]) |=> csr_q.stickySat)
        else $error("sticky saturation cleared without a write");

    AST_OVF_DYN: assert property (
        accReq.valid && !accReq.signedOp && !carry |=> !csr_q.ovf)
        else $error("overflow flag not re-evaluated");

    AST_OVF_SGN_CLR: assert property (
        sgnReq && !sgnOvf |=> !csr_q.ovf)
        else $error("overflow flag kept after clean signed add");

    AST_SAT_NO_OVF: assert property (
        sgnReq && csr_q.satEn && sgnOvf |=> !csr_q.ovf)
        else $error("overflow flag raised on a clamp");

    AST_STICKY_OVERFLOW_FLAG_CLR: assert property (
        wrCsr && !regWrData[BIT_STICKY_OVERFLOW_FLAG] && !ovfEvt |=> !csr_q.stickyOvf)
        else $error("sticky overflow not cleared by write");

    AST_STICKY_SATURATION_FLAG_CLR: assert property (
        wrCsr && !regWrData[BIT_STICKY_SATURATION_FLAG] && !satEvt |=> !csr_q.stickySat)
        else $error("sticky saturation not cleared by write");

    AST_SGN_PLAIN: assert property (
        sgnReq && !csr_q.fracEn && !(csr_q.satEn && sgnOvf)
        |=> accValue == $past(acc_q) + $past(accReq.addend))
        else $error("plain signed sum wrong");

    AST_FRAC_OVF: assert property (
        sgnReq && csr_q.fracEn && !csr_q.satEn && sgnOvf |=> csr_q.ovf && csr_q.stickyOvf)
        else $error("fractional overflow not flagged");

    AST_UNS_NO_SAT: assert property (
        accReq.valid && !accReq.signedOp && !csr_q.stickySat |=> !csr_q.stickySat)
        else $error("unsigned accumulation saturated");

    AST_DONE_SET: assert property (
        accReq.valid |=> accDone)
        else $error("done pulse missing");

    AST_DONE_CLR: assert property (
        !accReq.valid |=> !accDone)
        else $error("done pulse without accumulation");

    AST_RD_IDLE: assert property (
        !regRead |=> regRdData == RD_ZERO)
        else $error("read data not zero outside read");

    AST_RD_ACC: assert property (
        regRead && regAddr == OFS_ACC |=> regRdData == $past(acc_q))
        else $error("accumulator read data wrong");

    AST_WR_ACC: assert property (
        wrAcc && !accReq.valid |=> accValue == $past(regWrData))
        else $error("accumulator write not applied");

    AST_OVF_KEEP: assert property (
        !accReq.valid |=> csr_q.ovf == $past(csr_q.ovf))
        else $error("overflow flag changed without accumulation");

    AST_SAT_FLAG: assert property (
        sgnReq && csr_q.satEn && sgnOvf |=> csr_q.stickySat && intStat_q[INT_SAT])
        else $error("saturation not flagged");

    AST_SAT_POS: assert property (
        sgnReq && csr_q.satEn && sgnOvf && !acc_q[ACC_MSB] |=> accValue == ACC_MAX)
        else $error("positive saturation value wrong");

    AST_SAT_NEG: assert property (
        sgnReq && csr_q.satEn && sgnOvf && acc_q[ACC_MSB] |=> accValue == ACC_MIN)
        else $error("negative saturation value wrong");

    AST_FRAC_SHIFT: assert property (
        sgnReq && csr_q.fracEn && !sgnOvf
        |=> accValue == $past(acc_q) + {$past(accReq.addend[ACC_MSB-1:0]), 1'b0})
        else $error("fractional shift not applied");

    AST_UNS_PLAIN: assert property (
        accReq.valid && !accReq.signedOp |=> accValue == $past(acc_q) + $past(accReq.addend))
        else $error("modes affected unsigned accumulation");

    AST_NO_STICKY_OVERFLOW_FLAG_SAT: assert property (
        sgnReq && csr_q.satEn && !csr_q.stickyOvf |=> !csr_q.stickyOvf)
        else $error("sticky overflow set in saturation mode");

    AST_IRQ_LEVEL: assert property (
        (sgnReq && csr_q.satEn && sgnOvf && intEn_q[INT_SAT] && !wrEn) |=> irq)
        else $error("enabled saturation did not raise interrupt");

    COV_UNS_CARRY: cover property (accReq.valid && !accReq.signedOp && carry);
    COV_SAT_POS: cover property (sgnReq && csr_q.satEn && sgnOvf && !acc_q[ACC_MSB]);
    COV_SAT_RECOVER: cover property (satEvt ##1 sgnReq && !sgnOvf);
    COV_FRAC_OVF: cover property (sgnReq && csr_q.fracEn && !csr_q.satEn && sgnOvf);
    COV_SAT_NEG: cover property (sgnReq && csr_q.satEn && sgnOvf && acc_q[ACC_MSB]);
endmodule : mas_accumulator

/* File: tb/testbench.sv */
// Self-checking bench for the multiply-accumulate status block
`timescale 1ns/1ps

`define CHK(what, exp, got) \
    nTests++; \
    if ((got) !== (exp)) \
    begin \
        badCount++; \
        $display("BAD %s expected %h seen %h", what, exp, got); \
    end

module testbench;
    import mas_pkg::*;

    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdData;
    mas_acc_req_t accReq = '0;
    logic [ACC_W-1:0] accValue;
    logic accDone;
    logic irq;
    int badCount = 0;
    int nTests = 0;
    int cycles = 0;

    mas_accumulator mas_accumulator_inst (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdData(regRdData),
        .accReq(accReq),
        .accValue(accValue),
        .accDone(accDone),
        .irq(irq)
    );

    always #5 clk_sys = ~clk_sys;

    task automatic giveVerdict();
        $display("Comparisons %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : giveVerdict

    // Hang guard, well beyond the roughly 110 cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            badCount++;
            giveVerdict();
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        `CHK("read data", exp, regRdData)
    endtask : rd

    task automatic acc(input logic s, input logic [ACC_W-1:0] a,
                       input logic [ACC_W-1:0] exp);
        @(posedge clk_sys);
        accReq <= '{1'b1, s, a};
        @(posedge clk_sys);
        accReq.valid <= 1'b0;
        #1;
        `CHK("done", 1'b1, accDone)
        `CHK("accumulator", exp, accValue)
    endtask : acc

    task automatic irqIs(input logic exp);
        @(posedge clk_sys);
        #1;
        `CHK("irq", exp, irq)
    endtask : irqIs

    // Expected control and status word, reserved bits zero
    function automatic logic [DATA_W-1:0] csr(input logic [4:0] f);
        return {24'h000000, f[4:3], 3'h0, f[2:0]};
    endfunction : csr

    initial
    begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(OFS_CSR, RD_ZERO);
        rd(OFS_ACC, ACC_RST);
        rd(4'hf, RD_ZERO);
        wr(OFS_INT_EN, 32'h00000003);
        wr(OFS_CSR, csr(5'b11000));
        wr(OFS_ACC, 32'hffffffff);
        acc(1'b0, 32'h00000001, 32'h00000000);
        rd(OFS_CSR, csr(5'b11110));
        irqIs(1'b1);
        acc(1'b0, 32'h00000001, 32'h00000001);
        rd(OFS_CSR, csr(5'b11100));
        wr(OFS_INT_CLR, 32'h00000003);
        rd(OFS_INT_STAT, RD_ZERO);
        irqIs(1'b0);
        wr(OFS_CSR, csr(5'b00000));
        rd(OFS_CSR, csr(5'b00000));
        wr(OFS_ACC, ACC_MAX);
        acc(1'b1, 32'h00000001, ACC_MIN);
        rd(OFS_CSR, csr(5'b00110));
        acc(1'b1, 32'h00000001, 32'h80000001);
        rd(OFS_CSR, csr(5'b00100));
        wr(OFS_ACC, ACC_MIN);
        acc(1'b1, 32'hffffffff, ACC_MAX);
        wr(OFS_CSR, csr(5'b10000));
        wr(OFS_ACC, ACC_RST);
        acc(1'b1, 32'h00000003, 32'h00000006);
        wr(OFS_ACC, 32'h40000000);
        acc(1'b1, 32'h20000000, ACC_MIN);
        rd(OFS_CSR, csr(5'b10110));
        acc(1'b0, 32'h00000003, 32'h80000003);
        wr(OFS_CSR, csr(5'b01000));
        wr(OFS_ACC, ACC_MAX);
        acc(1'b1, 32'h00000001, ACC_MAX);
        rd(OFS_CSR, csr(5'b01001));
        rd(OFS_INT_STAT, 32'h00000003);
        acc(1'b1, 32'hffffffff, 32'h7ffffffe);
        rd(OFS_CSR, csr(5'b01001));
        wr(OFS_ACC, ACC_MIN);
        acc(1'b1, 32'hffffffff, ACC_MIN);
        acc(1'b1, 32'h00000001, 32'h80000001);
        acc(1'b0, 32'hffffffff, 32'h80000000);
        wr(OFS_CSR, csr(5'b11001));
        wr(OFS_ACC, 32'h60000000);
        acc(1'b1, 32'h20000000, ACC_MAX);
        wr(OFS_INT_EN, 32'h00000000);
        irqIs(1'b0);
        rd(OFS_INT_EN, RD_ZERO);
        wr(OFS_INT_EN, 32'h00000001);
        irqIs(1'b1);
        wr(OFS_INT_CLR, 32'h00000001);
        rd(OFS_INT_STAT, 32'h00000002);
        irqIs(1'b0);
        rd(OFS_INT_CLR, RD_ZERO);
        wr(OFS_CSR, csr(5'b00000));
        rd(OFS_CSR, csr(5'b00000));
        giveVerdict();
    end
endmodule : testbench
